/* File: logic/plt_pkg.sv */
`default_nettype none
// ==========================================================
// shared constants of the link-side transmit controller
package plt_pkg;
    // control line codes
    localparam logic [1:0] CTL_IDLE     = 2'h0;
    localparam logic [1:0] CTL_HOLD     = 2'h1;
    localparam logic [1:0] CTL_TRANSMIT = 2'h2;
    localparam logic [1:0] CTL_GRANT    = 2'h3;

    // register offsets (byte addresses)
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_SPEED     = 8'h04;
    localparam logic [7:0] REG_LEN       = 8'h08;
    localparam logic [7:0] REG_HOLD      = 8'h0c;
    localparam logic [7:0] REG_STATUS    = 8'h10;
    localparam logic [7:0] REG_DATA_BASE = 8'h40;

    // control register fields
    localparam int CTRL_LPS_ON     = 0;
    localparam int CTRL_LPS_PULSED = 1;
    localparam int CTRL_MSC_EN     = 2;
    localparam int CTRL_GO         = 3;
    localparam int CTRL_CONCAT     = 4;
    localparam int CTRL_CANCEL     = 5;
    localparam logic [5:0] CTRL_RESET = 6'h00;

    // status register fields
    localparam int STAT_BUSY     = 0;
    localparam int STAT_DONE     = 1;
    localparam int STAT_LPS      = 2;
    localparam int STAT_CLK_SEEN = 3;
    localparam int STAT_STATE    = 4;
    localparam int STAT_DATA     = 8;

    // speed code fields
    localparam logic [7:0] SPD_RATE_MASK = 8'hc0;
    localparam logic [7:0] SPD_S100      = 8'h00;
    localparam logic [7:0] SPEED_RESET   = 8'h00;

    // hold limit before transmit or idle
    localparam logic [5:0] MAX_HOLD = 6'h2f;

    // timing
    localparam int CLK_MHZ         = 250;
    localparam int LINK_STOP_NS    = 1000;
    localparam int LINK_STOP_CYC   = (LINK_STOP_NS * CLK_MHZ) / 1000;
    localparam int LPS_HIGH_NS     = 400;
    localparam int LPS_LOW_NS      = 600;
    localparam int LPS_HIGH_CYC    = (LPS_HIGH_NS * CLK_MHZ + 999) / 1000;
    localparam int LPS_LOW_CYC     = (LPS_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int RESTORE_NS      = 10000;
    localparam int RESTORE_CYC     = (RESTORE_NS * CLK_MHZ + 999) / 1000;
endpackage
`default_nettype wire

/* File: logic/plt_lps_gen.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// link power status driver: level or pulse train
module plt_lps_gen #(
    parameter int HIGH_CYC = plt_pkg::LPS_HIGH_CYC,
    parameter int LOW_CYC  = plt_pkg::LPS_LOW_CYC
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic active,
    input  wire logic pulsed,
    output var  logic lps
);
    localparam int CW = $clog2(HIGH_CYC + LOW_CYC + 1);
    localparam logic [CW-1:0] PERIOD = CW'(HIGH_CYC + LOW_CYC);
    localparam logic [CW-1:0] HIGH   = CW'(HIGH_CYC);

    logic [CW-1:0] phase_r;
    logic [CW-1:0] run_r;

    // ==========================================================
    // phase counter across one pulse period
    always_ff @(posedge clk) begin
        if (rst || !active || phase_r == PERIOD - 1'b1) begin
            phase_r <= '0;
        end else begin
            phase_r <= phase_r + 1'b1;
        end
    end

    // pulsed duty kept inside 20..55 percent
    // [RULE16] level or pulse
    always_ff @(posedge clk) begin
        if (rst || !active) begin
            lps <= 1'b0;
        end else if (pulsed) begin
            lps <= (phase_r < HIGH);
        end else begin
            lps <= 1'b1;
        end
    end

    // helper: length of current high run
    always_ff @(posedge clk) begin
        if (rst || !lps || !pulsed) begin
            run_r <= '0;
        end else if (run_r != PERIOD) begin
            run_r <= run_r + 1'b1;
        end
    end

    // [RULE17] high time bounded
    property p_lps_high_run;
        @(posedge clk) disable iff (rst)
        (pulsed && $stable(pulsed) && active) |-> (run_r <= HIGH);
    endproperty
    a_lps_high_run: assert property (p_lps_high_run) else $error("lps pulse high too long"); // [RULE17]
endmodule
`default_nettype wire

/* File: logic/plt_link_ctl.sv */
// Rules for this block and for the PHY it works with
// [RULE1] PHY grants, idles, then releases lines
// [RULE2] control codes idle hold transmit grant
// [RULE3] at most one idle after taking
// [RULE4] hold at most 47 cycles
// [RULE5] transmit code with packet data together
// [RULE6] one hold or idle ends packet
// [RULE7] one more idle, then release lines
// [RULE8] next speed code during terminating hold
// [RULE9] multispeed concatenation enable bit
// [RULE10] never S100 after faster packet
// [RULE11] PHY idles after regaining interface
// [RULE12] cancel: holds, two idles, release
// [RULE13] cancel without holds uses three idles
// [RULE14] PHY drops requests while not operational
// [RULE15] PHY discards status while not operational
// [RULE16] power status pulsed or level
// [RULE17] pulse duty between 20 and 55 percent
// [RULE18] PHY resets interface after power status low
// [RULE19] stop and tristate within 1 us
// [RULE20] PHY tristates lines at logic 0
// [RULE21] reassert power status after restore time
// [RULE22] long low disables PHY clock
// [RULE23] PHY clock returns after reassertion
// [RULE24] PHY measures intervals with counters
`timescale 1ns/1ps
`default_nettype none
module plt_link_ctl #(
    parameter int DEPTH       = 16,
    parameter int RESTORE_CYC = plt_pkg::RESTORE_CYC
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       wb_cyc,
    input  wire logic       wb_stb,
    input  wire logic       wb_we,
    input  wire logic [7:0] wb_adr,
    input  wire logic [3:0] wb_sel,
    input  wire logic [31:0] wb_dat_wr,
    output var  logic [31:0] wb_dat_rd,
    output var  logic       wb_ack,
    input  wire logic       phy_output_clock,
    input  wire logic [1:0] ctl_in,
    output var  logic [1:0] ctl_out,
    output var  logic       ctl_oe_n,
    input  wire logic [7:0] data_in,
    output var  logic [7:0] data_out,
    output var  logic       data_oe_n,
    output var  logic       link_request_line,
    output var  logic       link_power_status
);
    localparam int IW = $clog2(DEPTH);
    localparam int RW = $clog2(RESTORE_CYC + 1);
    localparam logic [7:0] DATA_END = 8'(plt_pkg::REG_DATA_BASE + 4 * DEPTH);

    typedef enum logic [2:0] {
        S_IDLE     = 3'h0,
        S_WAIT     = 3'h1,
        S_PHY_IDLE = 3'h2,
        S_HOLD     = 3'h3,
        S_TX       = 3'h4,
        S_TERM     = 3'h5,
        S_REL      = 3'h6,
        S_CANCEL   = 3'h7
    } plt_state_t;

    plt_state_t     st_r;
    logic [5:0]     ctrl_r;
    logic [15:0]    speed_r;
    logic [IW:0]    len_r;
    logic [5:0]     hold_r;
    logic [7:0]     buf_r [DEPTH];
    logic [IW:0]    idx_r;
    logic [5:0]     cnt_r;
    logic           go_r;
    logic           done_r;
    logic           concat_r;
    logic           lps_act_r;
    logic [RW-1:0]  restore_r;
    logic           clk_seen_r;
    logic [2:0]     pclk_s;
    logic [1:0]     ctl_s1;
    logic [1:0]     ctl_s2;
    logic [7:0]     dat_s1;
    logic [7:0]     dat_s2;
    logic           en;
    logic           wb_hit;
    logic           wr;
    logic           concat_ok;
    logic           start_cancel;
    logic [5:0]     hold_w;

    // ==========================================================
    // pin synchronisers
    always_ff @(posedge clk) begin
        if (rst) begin
            pclk_s <= 3'h0;
            ctl_s1 <= 2'h0;
            ctl_s2 <= 2'h0;
            dat_s1 <= 8'h00;
            dat_s2 <= 8'h00;
        end else begin
            pclk_s <= {pclk_s[1:0], phy_output_clock};
            ctl_s1 <= ctl_in;
            ctl_s2 <= ctl_s1;
            dat_s1 <= data_in;
            dat_s2 <= dat_s1;
        end
    end

    // one pulse per phy clock rising edge
    assign en = pclk_s[1] & ~pclk_s[2];

    // ==========================================================
    // wishbone slave
    assign wb_hit = wb_cyc & wb_stb & ~wb_ack;
    assign wr     = wb_cyc & wb_stb & wb_ack & wb_we & wb_sel[0]; // lands at the edge that sees ack
    assign hold_w = (wb_dat_wr[5:0] > plt_pkg::MAX_HOLD) ? plt_pkg::MAX_HOLD : wb_dat_wr[5:0];

    // ack one cycle after the request, dropped the next
    always_ff @(posedge clk) begin
        if (rst) begin
            wb_ack <= 1'b0;
        end else begin
            wb_ack <= wb_hit;
        end
    end

    // control, speed, length and hold registers
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_r  <= plt_pkg::CTRL_RESET;
            speed_r <= {plt_pkg::SPEED_RESET, plt_pkg::SPEED_RESET};
            len_r   <= '0;
            hold_r  <= 6'h00;
            go_r    <= 1'b0;
        end else begin
            go_r <= wr && wb_adr == plt_pkg::REG_CTRL && wb_dat_wr[plt_pkg::CTRL_GO];
            if (wr && wb_adr == plt_pkg::REG_CTRL) begin
                ctrl_r <= wb_dat_wr[5:0] & ~(6'h1 << plt_pkg::CTRL_GO);
            end
            if (wr && wb_adr == plt_pkg::REG_SPEED) begin
                speed_r[7:0] <= wb_dat_wr[7:0];
                if (wb_sel[1]) begin
                    speed_r[15:8] <= wb_dat_wr[15:8];
                end
            end
            if (wr && wb_adr == plt_pkg::REG_LEN) begin
                len_r <= (wb_dat_wr[IW:0] > (IW+1)'(DEPTH)) ? (IW+1)'(DEPTH) : wb_dat_wr[IW:0];
            end
            // [RULE4] hold count clamped
            if (wr && wb_adr == plt_pkg::REG_HOLD) begin
                hold_r <= hold_w;
            end
        end
    end

    // packet bytes, one per word
    always_ff @(posedge clk) begin
        if (wr && wb_adr >= plt_pkg::REG_DATA_BASE && wb_adr < DATA_END) begin
            buf_r[wb_adr[IW+1:2]] <= wb_dat_wr[7:0];
        end
    end

    // read mux, unmapped reads zero
    always_ff @(posedge clk) begin
        if (rst) begin
            wb_dat_rd <= 32'h0;
        end else if (wb_hit) begin
            unique case (wb_adr)
                plt_pkg::REG_CTRL:   wb_dat_rd <= {26'h0, ctrl_r};
                plt_pkg::REG_SPEED:  wb_dat_rd <= {16'h0, speed_r};
                plt_pkg::REG_LEN:    wb_dat_rd <= 32'(len_r);
                plt_pkg::REG_HOLD:   wb_dat_rd <= {26'h0, hold_r};
                plt_pkg::REG_STATUS: wb_dat_rd <= {16'h0, dat_s2, 1'b0, st_r,
                                                   clk_seen_r, lps_act_r, done_r, st_r != S_IDLE};
                default:             wb_dat_rd <= 32'h0;
            endcase
        end
    end

    // ==========================================================
    // link power status with restore guard
    // [RULE21] restore time before reassert
    always_ff @(posedge clk) begin
        if (rst) begin
            lps_act_r <= 1'b0;
            restore_r <= '0;
        end else if (lps_act_r && !ctrl_r[plt_pkg::CTRL_LPS_ON]) begin
            lps_act_r <= 1'b0;
            restore_r <= RW'(RESTORE_CYC);
        end else if (!lps_act_r && restore_r != '0) begin
            restore_r <= restore_r - 1'b1;
        end else if (!lps_act_r && ctrl_r[plt_pkg::CTRL_LPS_ON]) begin
            lps_act_r <= 1'b1;
        end
    end

    plt_lps_gen u_lps (
        .clk    (clk),
        .rst    (rst),
        .active (lps_act_r),
        .pulsed (ctrl_r[plt_pkg::CTRL_LPS_PULSED]),
        .lps    (link_power_status)
    );

    // phy clock seen since power status came up
    // [RULE23] clock return tracked
    always_ff @(posedge clk) begin
        if (rst || !lps_act_r) begin
            clk_seen_r <= 1'b0;
        end else if (en) begin
            clk_seen_r <= 1'b1;
        end
    end

    // ==========================================================
    // transmit handover sequencer
    // [RULE10] no S100 after faster packet
    assign concat_ok = concat_r &&
        !(ctrl_r[plt_pkg::CTRL_MSC_EN] &&
          (speed_r[15:8] & plt_pkg::SPD_RATE_MASK) == plt_pkg::SPD_S100 &&
          (speed_r[7:0] & plt_pkg::SPD_RATE_MASK) != plt_pkg::SPD_S100);
    assign start_cancel = ctrl_r[plt_pkg::CTRL_CANCEL] || len_r == '0;

    always_ff @(posedge clk) begin
        if (rst || !lps_act_r) begin
            // [RULE19] stop, tristate, end low
            st_r              <= S_IDLE;
            ctl_out           <= plt_pkg::CTL_IDLE;
            data_out          <= 8'h00;
            ctl_oe_n          <= 1'b1;
            data_oe_n         <= 1'b1;
            link_request_line <= 1'b0;
            idx_r             <= '0;
            cnt_r             <= 6'h00;
            concat_r          <= 1'b0;
        end else begin
            unique case (st_r)
                S_IDLE: if (go_r && clk_seen_r) begin
                    st_r              <= S_WAIT;
                    link_request_line <= 1'b1;
                    concat_r          <= ctrl_r[plt_pkg::CTRL_CONCAT];
                end
                // [RULE2] wait for grant code
                S_WAIT: if (en && ctl_s2 == plt_pkg::CTL_GRANT) begin
                    st_r              <= S_PHY_IDLE;
                    link_request_line <= 1'b0;
                end
                // [RULE1] take lines after phy idle
                S_PHY_IDLE: if (en && ctl_s2 == plt_pkg::CTL_IDLE) begin
                    ctl_oe_n  <= 1'b0;
                    data_oe_n <= 1'b0;
                    idx_r     <= '0;
                    data_out  <= 8'h00;
                    if (hold_r != 6'h00) begin
                        // [RULE3] no leading idle
                        st_r    <= S_HOLD;
                        ctl_out <= plt_pkg::CTL_HOLD;
                        cnt_r   <= hold_r;
                    end else if (start_cancel) begin
                        // [RULE13] three idles without holds
                        st_r    <= S_CANCEL;
                        ctl_out <= plt_pkg::CTL_IDLE;
                        cnt_r   <= 6'h3;
                    end else begin
                        // [RULE5] transmit with first byte
                        st_r     <= S_TX;
                        ctl_out  <= plt_pkg::CTL_TRANSMIT;
                        data_out <= buf_r[0];
                        idx_r    <= (IW+1)'(1);
                    end
                end
                S_HOLD: if (en) begin
                    if (cnt_r != 6'h1) begin
                        cnt_r <= cnt_r - 6'h1;
                    end else if (start_cancel) begin
                        // [RULE12] two idles after holds
                        st_r    <= S_CANCEL;
                        ctl_out <= plt_pkg::CTL_IDLE;
                        cnt_r   <= 6'h2;
                    end else begin
                        st_r     <= S_TX;
                        ctl_out  <= plt_pkg::CTL_TRANSMIT;
                        data_out <= buf_r[0];
                        idx_r    <= (IW+1)'(1);
                    end
                end
                S_TX: if (en) begin
                    if (idx_r != len_r) begin
                        data_out <= buf_r[idx_r[IW-1:0]];
                        idx_r    <= idx_r + 1'b1;
                    end else begin
                        // [RULE6] hold to concatenate, else idle
                        // [RULE8] next speed on data lines
                        st_r     <= S_TERM;
                        ctl_out  <= concat_ok ? plt_pkg::CTL_HOLD : plt_pkg::CTL_IDLE;
                        data_out <= (concat_ok && ctrl_r[plt_pkg::CTRL_MSC_EN]) ? speed_r[15:8] : 8'h00;
                    end
                end
                // [RULE7] one more idle before release
                S_TERM: if (en) begin
                    st_r     <= S_REL;
                    ctl_out  <= plt_pkg::CTL_IDLE;
                    data_out <= 8'h00;
                end
                S_REL: if (en) begin
                    ctl_oe_n  <= 1'b1;
                    data_oe_n <= 1'b1;
                    st_r      <= concat_ok ? S_WAIT : S_IDLE;
                    concat_r  <= 1'b0;
                end
                S_CANCEL: if (en) begin
                    if (cnt_r != 6'h1) begin
                        cnt_r <= cnt_r - 6'h1;
                    end else begin
                        ctl_oe_n  <= 1'b1;
                        data_oe_n <= 1'b1;
                        st_r      <= S_IDLE;
                    end
                end
            endcase
        end
    end

    // done flag, set wins over write-one clear
    always_ff @(posedge clk) begin
        if (rst) begin
            done_r <= 1'b0;
        end else if (en && ((st_r == S_REL && !concat_ok) || (st_r == S_CANCEL && cnt_r == 6'h1))) begin
            done_r <= 1'b1;
        end else if (wr && wb_adr == plt_pkg::REG_STATUS && wb_dat_wr[plt_pkg::STAT_DONE]) begin
            done_r <= 1'b0;
        end
    end

    // ==========================================================
    // checks
    property p_take_no_idle; // [RULE3]
        @(posedge clk) disable iff (rst)
        (st_r == S_PHY_IDLE && en && ctl_s2 == plt_pkg::CTL_IDLE && lps_act_r && hold_r != 6'h00)
            |=> (!ctl_oe_n && ctl_out == plt_pkg::CTL_HOLD);
    endproperty
    a_take_no_idle: assert property (p_take_no_idle) else $error("link idled before hold"); // [RULE3]

    property p_hold_limit;
        @(posedge clk) disable iff (rst)
        (st_r == S_HOLD) |-> (cnt_r <= plt_pkg::MAX_HOLD && cnt_r != 6'h00);
    endproperty
    a_hold_limit: assert property (p_hold_limit) else $error("hold count out of range"); // [RULE4]

    property p_tx_code;
        @(posedge clk) disable iff (rst)
        (st_r == S_TX) |-> (ctl_out == plt_pkg::CTL_TRANSMIT && !ctl_oe_n && !data_oe_n);
    endproperty
    a_tx_code: assert property (p_tx_code) else $error("transmit without code or drive"); // [RULE5]

    property p_rel_idle;
        @(posedge clk) disable iff (rst)
        (st_r == S_REL) |-> (ctl_out == plt_pkg::CTL_IDLE && data_out == 8'h00 && $past(st_r) != S_TX);
    endproperty
    a_rel_idle: assert property (p_rel_idle) else $error("second idle missing"); // [RULE7]

    property p_release;
        @(posedge clk) disable iff (rst)
        (st_r == S_REL && en && lps_act_r) |=> (ctl_oe_n && data_oe_n);
    endproperty
    a_release: assert property (p_release) else $error("lines not released"); // [RULE7]

    property p_speed_code;
        @(posedge clk) disable iff (rst)
        (st_r == S_TX && en && idx_r == len_r && lps_act_r && concat_ok && ctrl_r[plt_pkg::CTRL_MSC_EN])
            |=> (ctl_out == plt_pkg::CTL_HOLD && data_out == $past(speed_r[15:8]));
    endproperty
    a_speed_code: assert property (p_speed_code) else $error("speed code not on data lines"); // [RULE8]

    property p_no_slow_concat;
        @(posedge clk) disable iff (rst)
        (st_r == S_TERM && ctl_out == plt_pkg::CTL_HOLD && ctrl_r[plt_pkg::CTRL_MSC_EN] &&
         (speed_r[7:0] & plt_pkg::SPD_RATE_MASK) != plt_pkg::SPD_S100)
            |-> ((data_out & plt_pkg::SPD_RATE_MASK) != plt_pkg::SPD_S100);
    endproperty
    a_no_slow_concat: assert property (p_no_slow_concat) else $error("S100 after faster packet"); // [RULE10]

    property p_cancel_idles;
        @(posedge clk) disable iff (rst)
        (st_r == S_CANCEL) |-> (ctl_out == plt_pkg::CTL_IDLE && cnt_r <= 6'h3 && cnt_r != 6'h00);
    endproperty
    a_cancel_idles: assert property (p_cancel_idles) else $error("cancel idle count wrong"); // [RULE12]

    property p_stop_fast;
        @(posedge clk) disable iff (rst)
        !lps_act_r |=> (ctl_oe_n && data_oe_n && ctl_out == plt_pkg::CTL_IDLE &&
                        data_out == 8'h00 && !link_request_line);
    endproperty
    a_stop_fast: assert property (p_stop_fast) else $error("activity after power status drop"); // [RULE19]

    property p_restore;
        @(posedge clk) disable iff (rst)
        $fell(lps_act_r) |=> !lps_act_r [*8];
    endproperty
    a_restore: assert property (p_restore) else $error("power status reasserted too soon"); // [RULE21]
endmodule
`default_nettype wire

/* File: logic/README_none.sv */
`default_nettype none
`default_nettype wire

/* File: tb/plt_phy_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// phy model: clock source, grant, power status watch
module plt_phy_model #(
    parameter int RST_CYC = 60,
    parameter int DIS_CYC = 200
) (
    input  wire logic       pws,
    input  wire logic       req,
    input  wire logic [1:0] code_o,
    input  wire logic       code_oe_n,
    input  wire logic [7:0] byte_o,
    input  wire logic       byte_oe_n,
    output var  logic       phy_clk,
    output var  logic [1:0] code_i,
    output var  logic [7:0] byte_i
);
    logic       osc = 1'b0;
    logic       drv = 1'b1;
    logic       seen = 1'b0;
    logic       cat = 1'b0;
    logic [1:0] pctl = 2'h0;
    logic [1:0] held = 2'h0;
    logic [1:0] lastc = 2'h0;
    logic [1:0] term = 2'h0;
    int         lowc = DIS_CYC;
    int         st = 0;
    logic [9:0] log_q[$];
    // free oscillator near 49 MHz
    initial forever #10.17 osc = ~osc;
    assign phy_clk = osc & (lowc < DIS_CYC);
    // bus holder on code lines, changing pattern on data
    assign code_i = !code_oe_n ? code_o : drv ? pctl : held;
    assign byte_i = !byte_oe_n ? byte_o : drv ? 8'h00 : ~byte_o;
    // low time counted, any pulse clears it
    always @(posedge osc) begin
        held <= code_i;
        lowc <= pws ? 0 : (lowc < DIS_CYC ? lowc + 1 : lowc);
        // reset drops all, lines at 0
        if (lowc >= RST_CYC) begin
            st <= 0;
            drv <= 1'b1;
            pctl <= plt_pkg::CTL_IDLE;
            cat <= 1'b0;
        end else if (st == 0 && (req || cat)) begin
            st <= 1;
            pctl <= plt_pkg::CTL_GRANT;
        end else if (st == 1) begin
            st <= 2;
            pctl <= plt_pkg::CTL_IDLE;
        // link drives from the cycle after the phy idle
        end else if (st >= 2 && !code_oe_n) begin
            st <= 3;
            drv <= 1'b0;
            log_q.push_back({code_o, byte_o});
            seen <= 1'b1;
            lastc <= code_o;
            term <= lastc;
        end else if (st == 2) begin
            st <= 3;
            drv <= 1'b0;
            seen <= 1'b0;
        end else if (st == 3 && seen) begin
            st <= 0;
            drv <= 1'b1;
            cat <= (term == plt_pkg::CTL_HOLD);
        end
    end
endmodule
`default_nettype wire

/* File: tb/phy_link_transmit_and_reset_ctl_test.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// bench for the link-side transmit controller
module phy_link_transmit_and_reset_ctl_test;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, r;
    logic        ack, pclk, oe_n, boe_n, req, pws;
    logic [1:0]  ci, co;
    logic [7:0]  bi, bo;
    int          fails = 0;
    int          tests_run = 0;
    plt_link_ctl #(.RESTORE_CYC(8)) i_dut (.clk(clk), .rst(rst), .wb_cyc(cyc), .wb_stb(stb),
        .wb_we(we), .wb_adr(adr), .wb_sel(4'hf), .wb_dat_wr(wdat), .wb_dat_rd(rdat),
        .wb_ack(ack), .phy_output_clock(pclk), .ctl_in(ci), .ctl_out(co), .ctl_oe_n(oe_n),
        .data_in(bi), .data_out(bo), .data_oe_n(boe_n), .link_request_line(req),
        .link_power_status(pws));
    plt_phy_model i_phy (.pws(pws), .req(req), .code_o(co), .code_oe_n(oe_n), .byte_o(bo),
        .byte_oe_n(boe_n), .phy_clk(pclk), .code_i(ci), .byte_i(bi));
    // 250 MHz clock
    initial forever #2 clk = ~clk;
    task automatic wrap_up();
        if (fails == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("MISMATCH %s exp %h got %h", n, e, g);
            fails++;
        end
    endtask
    // one classic wishbone cycle
    task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    // start a transfer and wait for done
    task automatic pkt(input logic [31:0] len, input logic [31:0] hold, input logic [31:0] c);
        int n;
        n = 0;
        wbx(1'b1, plt_pkg::REG_STATUS, 32'h2);
        wbx(1'b1, plt_pkg::REG_LEN, len);
        wbx(1'b1, plt_pkg::REG_HOLD, hold);
        i_phy.log_q.delete();
        wbx(1'b1, plt_pkg::REG_CTRL, c | 32'h8);
        do begin
            wbx(1'b0, plt_pkg::REG_STATUS, 32'h0);
            n++;
        end while (r[1] !== 1'b1 && n < 400);
        chk("done", 1'b1, r[1]);
    endtask
    function automatic logic [9:0] lg(input int i);
        return i_phy.log_q[i];
    endfunction
    function automatic logic [1:0] lc(input int i);
        return i_phy.log_q[i][9:8];
    endfunction
    task automatic t_xfer();
        wbx(1'b1, plt_pkg::REG_DATA_BASE, 32'ha5);
        wbx(1'b1, 8'h44, 32'h3c);
        wbx(1'b1, plt_pkg::REG_SPEED, 32'h50);
        pkt(2, 0, 1);
        chk("len", 4, i_phy.log_q.size());
        chk("b0", {plt_pkg::CTL_TRANSMIT, 8'ha5}, lg(0));
        chk("b1", {plt_pkg::CTL_TRANSMIT, 8'h3c}, lg(1));
        chk("end", {plt_pkg::CTL_IDLE, plt_pkg::CTL_IDLE}, {lc(2), lc(3)});
        pkt(1, 50, 1);
        chk("hcnt", 50, i_phy.log_q.size());
        chk("h46", plt_pkg::CTL_HOLD, lc(46));
        chk("tx47", {plt_pkg::CTL_TRANSMIT, 8'ha5}, lg(47));
    endtask
    task automatic t_cancel();
        pkt(0, 2, 32'h21);
        chk("c2", {8'h0, plt_pkg::CTL_HOLD, plt_pkg::CTL_HOLD, plt_pkg::CTL_IDLE, plt_pkg::CTL_IDLE},
            {lc(0), lc(1), lc(2), lc(3)});
        pkt(0, 0, 32'h21);
        chk("c0n", 3, i_phy.log_q.size());
        chk("c0", {plt_pkg::CTL_IDLE, plt_pkg::CTL_IDLE, plt_pkg::CTL_IDLE}, {lc(0), lc(1), lc(2)});
    endtask
    task automatic t_concat();
        wbx(1'b1, plt_pkg::REG_SPEED, 32'h4050);
        pkt(1, 0, 32'h15);
        chk("spd", {plt_pkg::CTL_HOLD, 8'h40}, lg(1));
        wbx(1'b1, plt_pkg::REG_CTRL, 32'h1);
        repeat (400) @(posedge clk);
        wbx(1'b1, plt_pkg::REG_SPEED, 32'h0050);
        pkt(1, 0, 32'h15);
        chk("s100", plt_pkg::CTL_IDLE, lc(1));
    endtask
    task automatic t_power();
        int h;
        int l;
        h = 0;
        l = 0;
        wbx(1'b1, plt_pkg::REG_CTRL, 32'h3);
        repeat (300) @(posedge clk);
        while (pws !== 1'b0 && h < 999) begin
            @(posedge clk);
            h++;
        end
        while (pws !== 1'b1 && l < 999) begin
            @(posedge clk);
            l++;
        end
        h = 0;
        while (pws === 1'b1 && h < 999) begin
            @(posedge clk);
            h++;
        end
        l = 0;
        while (pws === 1'b0 && l < 999) begin
            @(posedge clk);
            l++;
        end
        chk("hi", plt_pkg::LPS_HIGH_CYC, h);
        chk("lo", plt_pkg::LPS_LOW_CYC, l);
        pkt(1, 0, 3);
        chk("plen", 3, i_phy.log_q.size());
        wbx(1'b1, plt_pkg::REG_CTRL, 32'h0);
        repeat (plt_pkg::LINK_STOP_CYC) @(posedge clk);
        chk("stop", 6'h30, {oe_n, boe_n, req, pws, co});
        repeat (1100) @(posedge clk);
        chk("clk", 1'b0, pclk);
        wbx(1'b1, plt_pkg::REG_CTRL, 32'h1);
        repeat (100) @(posedge clk);
        wbx(1'b0, plt_pkg::REG_STATUS, 32'h0);
        chk("seen", 1'b1, r[3]);
        pkt(2, 0, 1);
        chk("rlen", 4, i_phy.log_q.size());
    endtask
    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        wbx(1'b1, plt_pkg::REG_CTRL, 32'h8);
        repeat (20) @(posedge clk);
        chk("noreq", 1'b0, req);
        wbx(1'b1, plt_pkg::REG_CTRL, 32'h1);
        repeat (100) @(posedge clk);
        t_xfer();
        t_cancel();
        t_concat();
        t_power();
        wrap_up();
    end
    // watchdog
    initial begin
        #200000;
        fails++;
        wrap_up();
    end
endmodule
`default_nettype wire
